// *** rtl/osd_pkg.sv ***
// constants, types and register map of the bitmap window pixel path
// ****************************************************************
// ****************************************************************
package osd_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_WIN0_MODE = 8'h00;
    localparam logic [7:0] REG_WIN1_MODE = 8'h04;
    localparam logic [7:0] REG_TRANSP    = 8'h08;
    localparam logic [7:0] REG_ATTR_MODE = 8'h0c;
    localparam logic [7:0] REG_CLUT_ADDR = 8'h10;
    localparam logic [7:0] REG_CLUT_DATA = 8'h14;
    localparam logic [7:0] REG_STATUS    = 8'h18;
    localparam logic [2:0] PAL0_BLOCK    = 3'h1;
    localparam logic [2:0] PAL1_BLOCK    = 3'h2;

    localparam logic [8:0]  MODE_RESET   = 9'h000;
    localparam logic [15:0] TRANSP_RESET = 16'h0000;
    localparam logic [7:0]  PAL_RESET    = 8'h00;

    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [1:0] DEPTH_1 = 2'h0;
    localparam logic [1:0] DEPTH_2 = 2'h1;
    localparam logic [1:0] DEPTH_4 = 2'h2;
    localparam logic [1:0] DEPTH_8 = 2'h3;
    localparam logic [2:0] BLEND_FULL = 3'h7;

    // colour conversion, coefficients scaled by 256
    localparam logic signed [9:0] CY_R  = 10'sd77;
    localparam logic signed [9:0] CY_G  = 10'sd150;
    localparam logic signed [9:0] CY_B  = 10'sd29;
    localparam logic signed [9:0] CB_R  = -10'sd43;
    localparam logic signed [9:0] CB_G  = -10'sd85;
    localparam logic signed [9:0] CB_B  = 10'sd128;
    localparam logic signed [9:0] CR_R  = 10'sd128;
    localparam logic signed [9:0] CR_G  = -10'sd107;
    localparam logic signed [9:0] CR_B  = -10'sd21;
    localparam logic signed [19:0] C_OFFSET = 20'sh08000;
    localparam logic signed [19:0] C_ROUND  = 20'sh00080;

    // blink base half period
    localparam int unsigned CLK_PERIOD_NS      = 50;
    localparam int unsigned BLINK_BASE_NS      = 50000000;
    localparam int unsigned BLINK_BASE_DEFAULT = BLINK_BASE_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } ycc_t;

    typedef struct packed {
        logic       attrSel;
        logic [2:0] blend;
        logic       transpEn;
        logic       rgbEn;
        logic [1:0] depth;
        logic       enable;
    } win_mode_t;

endpackage

// *** rtl/osd_bitmap_pixel_path.sv ***
// bitmap window unpack, palette, colour table, rgb565 conversion and blend
`timescale 1ns/1ps
module osd_bitmap_pixel_path #(
    parameter int unsigned BLINK_BASE_CYCLES = osd_pkg::BLINK_BASE_DEFAULT
) (
    input  wire logic          clk,         // pixel clock
    input  wire logic          reset_n,     // async reset, active low
    input  wire logic          clkEn,       // freezes all state but the reset synchroniser when low
    input  wire logic [7:0]    regAddr,     // register byte address
    input  wire logic [31:0]   regWrData,   // register write data
    input  wire logic          regWr,       // write strobe
    input  wire logic          regRd,       // read strobe
    output logic [31:0]        regRdData,   // read data, cycle after strobe
    input  wire logic [31:0]   win0Word,    // window 0 fetched word
    input  wire logic          win0Valid,   // window 0 word valid
    output logic               win0Ready,   // window 0 word taken
    input  wire logic [31:0]   win1Word,    // window 1 fetched word
    input  wire logic          win1Valid,   // window 1 word valid
    output logic               win1Ready,   // window 1 word taken
    input  wire osd_pkg::ycc_t videoPix,    // underlying video pixel
    input  wire logic          videoValid,  // video pixel strobe
    output osd_pkg::ycc_t      mixPix,      // mixed pixel
    output logic               mixValid     // mixed pixel strobe
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rstMeta;
    logic rstSyncN;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] unpackPix(input logic [31:0] w, input logic [1:0] d,
                                             input logic [4:0] p);
        logic [7:0] b;
        b = 8'h00;
        case (d)
            osd_pkg::DEPTH_8: begin
                b = w[{p[1:0], 3'b000} +: 8];
                return b;
            end
            osd_pkg::DEPTH_4: begin
                b = w[{p[2:1], 3'b000} +: 8];
                return p[0] ? {4'h0, b[3:0]} : {4'h0, b[7:4]};
            end
            osd_pkg::DEPTH_2: begin
                b = w[{p[3:2], 3'b000} +: 8];
                return {6'h00, b[(3'd6 - {p[1:0], 1'b0}) +: 2]};
            end
            default: begin
                b = w[{p[4:3], 3'b000} +: 8];
                return {7'h00, b[3'd7 - p[2:0]]};
            end
        endcase
    endfunction

    function automatic logic [4:0] lastPos(input osd_pkg::win_mode_t m);
        if (m.rgbEn) begin
            return 5'h01;
        end
        case (m.depth)
            osd_pkg::DEPTH_8: return 5'h03;
            osd_pkg::DEPTH_4: return 5'h07;
            osd_pkg::DEPTH_2: return 5'h0f;
            default:          return 5'h1f;
        endcase
    endfunction

    function automatic logic [7:0] clip8(input logic signed [19:0] acc);
        logic signed [19:0] s;
        s = (acc + osd_pkg::C_ROUND) >>> 8;
        if (s < 0) begin
            return 8'h00;
        end else if (s > 20'sd255) begin
            return 8'hff;
        end
        return s[7:0];
    endfunction

    function automatic osd_pkg::ycc_t toYcc(input logic [15:0] c);
        logic signed [19:0] r;
        logic signed [19:0] g;
        logic signed [19:0] b;
        osd_pkg::ycc_t o;
        r = {12'h000, c[15:11], c[15:13]};
        g = {12'h000, c[10:5], c[10:9]};
        b = {12'h000, c[4:0], c[4:2]};
        o.y  = clip8(osd_pkg::CY_R * r + osd_pkg::CY_G * g + osd_pkg::CY_B * b);
        o.cb = clip8(osd_pkg::CB_R * r + osd_pkg::CB_G * g + osd_pkg::CB_B * b
                     + osd_pkg::C_OFFSET);
        o.cr = clip8(osd_pkg::CR_R * r + osd_pkg::CR_G * g + osd_pkg::CR_B * b
                     + osd_pkg::C_OFFSET);
        return o;
    endfunction

    function automatic logic [7:0] mix8(input logic [7:0] w, input logic [7:0] v,
                                        input logic [2:0] f);
        logic [11:0] s;
        s = 12'(w) * 12'(f) + 12'(v) * (12'd8 - 12'(f)) + 12'd4;
        if (f == osd_pkg::BLEND_FULL) begin
            return w;
        end
        return (s[11:3] > 9'd255) ? 8'hff : s[10:3];
    endfunction

    function automatic osd_pkg::ycc_t mixYcc(input osd_pkg::ycc_t w, input osd_pkg::ycc_t v,
                                             input logic [2:0] f);
        osd_pkg::ycc_t o;
        o.y  = mix8(w.y, v.y, f);
        o.cb = mix8(w.cb, v.cb, f);
        o.cr = mix8(w.cr, v.cr, f);
        return o;
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    osd_pkg::win_mode_t mode [2];
    logic [7:0]         palette [2][16];
    logic [15:0]        transpColor;
    logic               blinkEnable;
    logic [1:0]         blinkInterval;
    logic [7:0]         clutAddr;
    osd_pkg::ycc_t      clut [256];
    logic               blinkPhase;
    logic               held [2];

    wire logic       wrEn = regWr && clkEn;
    wire logic [2:0] palIdx = regAddr[4:2];

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mode[0]       <= osd_pkg::win_mode_t'(osd_pkg::MODE_RESET);
            mode[1]       <= osd_pkg::win_mode_t'(osd_pkg::MODE_RESET);
            transpColor   <= osd_pkg::TRANSP_RESET;
            blinkEnable   <= 1'b0;
            blinkInterval <= 2'h0;
        end else if (wrEn) begin
            if (regAddr == osd_pkg::REG_WIN0_MODE) begin
                mode[0] <= osd_pkg::win_mode_t'({1'b0, regWrData[7:0]});
            end
            if (regAddr == osd_pkg::REG_WIN1_MODE) begin
                mode[1] <= osd_pkg::win_mode_t'(regWrData[8:0]);
            end
            if (regAddr == osd_pkg::REG_TRANSP) begin
                transpColor <= regWrData[15:0];
            end
            if (regAddr == osd_pkg::REG_ATTR_MODE) begin
                blinkEnable   <= regWrData[0];
                blinkInterval <= regWrData[2:1];
            end
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            for (int w = 0; w < 2; w++) begin
                for (int i = 0; i < 16; i++) begin
                    palette[w][i] <= osd_pkg::PAL_RESET;
                end
            end
        end else if (wrEn && regAddr[1:0] == 2'b00) begin
            if (regAddr[7:5] == osd_pkg::PAL0_BLOCK) begin
                palette[0][{palIdx, 1'b0}] <= regWrData[7:0];
                palette[0][{palIdx, 1'b1}] <= regWrData[15:8];
            end
            if (regAddr[7:5] == osd_pkg::PAL1_BLOCK) begin
                palette[1][{palIdx, 1'b0}] <= regWrData[7:0];
                palette[1][{palIdx, 1'b1}] <= regWrData[15:8];
            end
        end
    end

    // table data write stores and advances the address
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            clutAddr <= 8'h00;
        end else if (wrEn && regAddr == osd_pkg::REG_CLUT_ADDR) begin
            clutAddr <= regWrData[7:0];
        end else if (wrEn && regAddr == osd_pkg::REG_CLUT_DATA) begin
            clutAddr <= clutAddr + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (wrEn && regAddr == osd_pkg::REG_CLUT_DATA) begin
            clut[clutAddr] <= osd_pkg::ycc_t'(regWrData[23:0]);
        end
    end

    logic [31:0] next_regRdData;
    always_comb begin
        next_regRdData = 32'h0000_0000;
        case (regAddr)
            osd_pkg::REG_WIN0_MODE: next_regRdData = {24'h000000, 8'(mode[0])};
            osd_pkg::REG_WIN1_MODE: next_regRdData = {23'h000000, mode[1]};
            osd_pkg::REG_TRANSP:    next_regRdData = {16'h0000, transpColor};
            osd_pkg::REG_ATTR_MODE: next_regRdData = {29'h0, blinkInterval, blinkEnable};
            osd_pkg::REG_CLUT_ADDR: next_regRdData = {24'h000000, clutAddr};
            osd_pkg::REG_CLUT_DATA: next_regRdData = {8'h00, clut[clutAddr]};
            osd_pkg::REG_STATUS:    next_regRdData = {29'h0, held[1], held[0], blinkPhase};
            default: begin
                if (regAddr[7:5] == osd_pkg::PAL0_BLOCK) begin
                    next_regRdData = {16'h0000, palette[0][{palIdx, 1'b1}],
                                      palette[0][{palIdx, 1'b0}]};
                end else if (regAddr[7:5] == osd_pkg::PAL1_BLOCK) begin
                    next_regRdData = {16'h0000, palette[1][{palIdx, 1'b1}],
                                      palette[1][{palIdx, 1'b0}]};
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            regRdData <= 32'h0000_0000;
        end else if (clkEn) begin
            regRdData <= regRd ? next_regRdData : 32'h0000_0000;
        end
    end

    // ************************************************************
    // blink timer
    // ************************************************************
    logic [31:0] blinkCount;
    wire logic [31:0] blinkLast = (32'(BLINK_BASE_CYCLES) << blinkInterval) - 32'd1;
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            blinkCount <= 32'h0000_0000;
            blinkPhase <= 1'b0;
        end else if (clkEn) begin
            if (blinkCount >= blinkLast) begin
                blinkCount <= 32'h0000_0000;
                blinkPhase <= !blinkPhase;
            end else begin
                blinkCount <= blinkCount + 32'd1;
            end
        end
    end

    // ************************************************************
    // word unpacking and palette lookup, one lane per window
    // ************************************************************
    logic [31:0]   word [2];
    logic [4:0]    pos [2];
    logic [7:0]    pix [2];
    logic [15:0]   rgbPix [2];
    logic [7:0]    clutIdx [2];
    logic          step [2];
    logic          ready [2];
    logic          show [2];
    logic          zeroPix [2];
    osd_pkg::ycc_t color [2];

    wire logic [31:0] inWord [2] = '{win0Word, win1Word};
    wire logic        inValid [2] = '{win0Valid, win1Valid};

    for (genvar w = 0; w < 2; w++) begin : g_lane
        assign pix[w]    = unpackPix(word[w], mode[w].depth, pos[w]);
        assign rgbPix[w] = pos[w][0] ? word[w][31:16] : word[w][15:0];
        assign show[w]   = held[w] && mode[w].enable;
        assign step[w]   = held[w] && videoValid;
        assign ready[w]  = !held[w] || (step[w] && pos[w] == lastPos(mode[w]));

        always_comb begin
            case (mode[w].depth)
                osd_pkg::DEPTH_8: clutIdx[w] = pix[w];
                osd_pkg::DEPTH_4: clutIdx[w] = palette[w][pix[w][3:0]];
                osd_pkg::DEPTH_2: clutIdx[w] = palette[w][{pix[w][1:0], pix[w][1:0]}];
                default:          clutIdx[w] = palette[w][{4{pix[w][0]}}];
            endcase
        end

        assign color[w]   = mode[w].rgbEn ? toYcc(rgbPix[w]) : clut[clutIdx[w]];
        assign zeroPix[w] = mode[w].rgbEn ? (rgbPix[w] == transpColor)
                                          : (pix[w] == 8'h00);

        always_ff @(posedge clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
                word[w] <= 32'h0000_0000;
                held[w] <= 1'b0;
                pos[w]  <= 5'h00;
            end else if (clkEn) begin
                if (ready[w] && inValid[w]) begin
                    word[w] <= inWord[w];
                    held[w] <= 1'b1;
                    pos[w]  <= 5'h00;
                end else if (ready[w]) begin
                    held[w] <= 1'b0;
                end else if (step[w]) begin
                    pos[w] <= pos[w] + 5'h01;
                end
            end
        end
    end

    assign win0Ready = ready[0];
    assign win1Ready = ready[1];

    // ************************************************************
    // blending
    // ************************************************************
    wire logic       attrMode  = mode[1].attrSel && show[1];
    wire logic [3:0] attr      = pix[1][3:0];
    wire logic       blinkHide = attrMode && blinkEnable && attr[3] && blinkPhase;
    logic [2:0]      factor [2];
    osd_pkg::ycc_t   stage0;
    osd_pkg::ycc_t   next_mixPix;

    always_comb begin
        factor[0] = attrMode ? attr[2:0] : mode[0].blend;
        factor[1] = mode[1].blend;
        for (int w = 0; w < 2; w++) begin
            if (mode[w].transpEn && !zeroPix[w]) begin
                factor[w] = osd_pkg::BLEND_FULL;
            end
        end
        stage0 = videoPix;
        if (show[0] && !blinkHide) begin
            stage0 = mixYcc(color[0], videoPix, factor[0]);
        end
        next_mixPix = stage0;
        if (show[1] && !mode[1].attrSel) begin
            next_mixPix = mixYcc(color[1], stage0, factor[1]);
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mixPix   <= '0;
            mixValid <= 1'b0;
        end else if (clkEn) begin
            mixValid <= videoValid;
            if (videoValid) begin
                mixPix <= next_mixPix;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncN);

    sequence s_pixel_in;
        clkEn && videoValid;
    endsequence

    property p_mix_follows_video;
        s_pixel_in |=> mixValid;
    endproperty
    a_mix_follows_video: assert property (p_mix_follows_video)
        else $error("mixed pixel missing after video pixel");

    property p_direct_index;
        held[0] && !mode[0].rgbEn && mode[0].depth == osd_pkg::DEPTH_8
            |-> clutIdx[0] == word[0][{pos[0][1:0], 3'b000} +: 8];
    endproperty
    a_direct_index: assert property (p_direct_index)
        else $error("8-bit pixel not used as table index");

    property p_one_bit_palette;
        held[0] && mode[0].depth == osd_pkg::DEPTH_1 && pix[0] == 8'h01
            |-> clutIdx[0] == palette[0][15];
    endproperty
    a_one_bit_palette: assert property (p_one_bit_palette)
        else $error("1-bit value 1 not mapped through field 15");

    property p_opaque;
        mode[0].transpEn && !zeroPix[0] |-> factor[0] == osd_pkg::BLEND_FULL;
    endproperty
    a_opaque: assert property (p_opaque)
        else $error("non-zero pixel not opaque under transparency");

    property p_zero_factor;
        s_pixel_in and (!show[0] && !show[1]) |=> mixPix == $past(videoPix);
    endproperty
    a_zero_factor: assert property (p_zero_factor)
        else $error("video not passed when no window shows");

    sequence s_last_8bpp;
        clkEn && step[0] && !mode[0].rgbEn && mode[0].depth == osd_pkg::DEPTH_8
            && pos[0] == 5'h03;
    endsequence

    property p_word_done;
        s_last_8bpp |-> win0Ready;
    endproperty
    a_word_done: assert property (p_word_done)
        else $error("word not released after fourth pixel");

    property p_blink_gate;
        !blinkEnable |-> !blinkHide;
    endproperty
    a_blink_gate: assert property (p_blink_gate)
        else $error("blink active without global enable");

    property p_rgb_transp;
        held[0] && mode[0].rgbEn && rgbPix[0] != transpColor |-> !zeroPix[0];
    endproperty
    a_rgb_transp: assert property (p_rgb_transp)
        else $error("rgb pixel wrongly transparent");

endmodule // osd_bitmap_pixel_path

// *** tb/fetch_source.sv ***
// fetch side model offering one word at a time to a window port
`timescale 1ns/1ps
module fetch_source (
    input  wire logic        clk,      // pixel clock
    input  wire logic        load,     // offer nextWord
    input  wire logic [31:0] nextWord, // word to offer
    input  wire logic        ready,    // window takes word
    output logic [31:0]      word,     // offered word
    output logic             valid     // word offered
);
    initial begin
        valid = 1'b0;
        word = 32'h0;
    end
    // released word shows its inverse, never the stale value
    always @(posedge clk) begin
        if (load) begin
            word <= nextWord;
            valid <= 1'b1;
        end else if (valid && ready) begin
            valid <= 1'b0;
            word <= ~word;
        end
    end
endmodule // fetch_source

// *** tb/osd_bitmap_pixel_path_test.sv ***
// self-checking bench for the bitmap window pixel path
`timescale 1ns/1ps
module osd_bitmap_pixel_path_test;
    logic          clk, reset_n, regWr, regRd, load0, videoValid, win0Valid, win0Ready, mixValid;
    logic          clkEn, load1, win1Valid, win1Ready;
    logic [7:0]    regAddr;
    logic [31:0]   regWrData, regRdData, word0, word1, nextWord;
    osd_pkg::ycc_t videoPix, mixPix;
    int            fails, comparisons;
    int            attrVal;
    logic [23:0]   attrVid;
    osd_bitmap_pixel_path #(.BLINK_BASE_CYCLES(8)) osd_bitmap_pixel_path_i (.clk(clk),
        .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .win0Word(word0),
        .win0Valid(win0Valid), .win0Ready(win0Ready), .win1Word(word1), .win1Valid(win1Valid),
        .win1Ready(win1Ready), .videoPix(videoPix), .videoValid(videoValid), .mixPix(mixPix),
        .mixValid(mixValid));
    fetch_source fetch_source_i (.clk(clk), .load(load0), .nextWord(nextWord),
        .ready(win0Ready), .word(word0), .valid(win0Valid));
    fetch_source fetch_source_1_i (.clk(clk), .load(load1), .nextWord(nextWord),
        .ready(win1Ready), .word(word1), .valid(win1Valid));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk) {regWr, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge clk) regWr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk) {regRd, regAddr} <= {1'b1, a};
        @(posedge clk) regRd <= 1'b0;
        #1 chk("regRdData", e, regRdData);
    endtask
    task automatic feed(logic [31:0] w, logic s = 1'b0);
        @(posedge clk) {load0, load1, nextWord} <= {!s, s, w};
        @(posedge clk) {load0, load1} <= 2'b00;
        #1;
        for (int t = 0; t < 50 && (s ? win1Valid : win0Valid) !== 1'b0; t++) @(posedge clk) #1;
        chk("fetchValid", 32'h0, 32'(s ? win1Valid : win0Valid));
    endtask
    task automatic px(logic [23:0] v, logic [23:0] e);
        @(posedge clk) {videoValid, videoPix} <= {1'b1, v};
        @(posedge clk) videoValid <= 1'b0;
        #1 chk("mixValid", 32'h1, 32'(mixValid));
        chk("mixPix", 32'(e), 32'(mixPix));
    endtask
    function automatic logic [23:0] mx(logic [23:0] w, logic [23:0] v, logic [2:0] f, logic op);
        logic [23:0] r;
        if (op || f == 3'h7) return w;
        for (int c = 0; c < 3; c++)
            r[c*8+:8] = 8'((int'(w[c*8+:8]) * int'(f) + int'(v[c*8+:8]) * (8 - int'(f)) + 4) >> 3);
        return r;
    endfunction
    // one word at depth code d, factor f, transparency te; identity palette
    task automatic run(logic [31:0] w, int d, logic [2:0] f, logic te);
        int b, p, v, k;
        logic [23:0] vid;
        b = 1 << d;
        wr(osd_pkg::REG_WIN0_MODE, 32'h1 | (d << 1) | (32'(te) << 4) | (32'(f) << 5));
        feed(w);
        for (int i = 0; i < (32 >> d); i++) begin
            p = i * b;
            v = int'(w >> ((p / 8) * 8 + 8 - (p % 8) - b)) & ((1 << b) - 1);
            k = (d == 1) ? v * 5 : (d == 0) ? v * 15 : v;
            vid = {8'(i * 9), 8'h80, 8'hc0};
            px(vid, mx(24'(k * 32'h010101), vid, f, te && v != 0));
        end
    endtask
    initial begin
        #100000 fails++;
        summarize();
    end
    initial begin
        {reset_n, regWr, regRd, regAddr, regWrData, load0, load1, nextWord, videoValid} = '0;
        videoPix = '0;
        clkEn = 1'b1;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(osd_pkg::REG_WIN0_MODE, 32'(osd_pkg::MODE_RESET));
        rd(osd_pkg::REG_TRANSP, 32'(osd_pkg::TRANSP_RESET));
        rd(8'h7c, 32'h0);
        wr(osd_pkg::REG_CLUT_ADDR, 32'h0);
        for (int k = 0; k < 16; k++) wr(osd_pkg::REG_CLUT_DATA, k * 32'h010101);
        for (int i = 0; i < 8; i++) begin
            wr(8'(8'h20 + 4 * i), {16'h0, 8'(2 * i + 1), 8'(2 * i)});
            wr(8'(8'h40 + 4 * i), 32'h0000ffff);
        end
        rd(8'h20, 32'h00000100);
        rd(8'h40, 32'h0000ffff);
        run(32'h0f0a0501, 3, 3'h7, 1'b0);
        run(32'h78563412, 2, 3'h7, 1'b0);
        run(32'h1b1b1b1b, 1, 3'h7, 1'b0);
        run(32'h3c0fa5c3, 0, 3'h7, 1'b0);
        run(32'h00050a0f, 3, 3'h4, 1'b0);
        run(32'h0f0a0501, 3, 3'h1, 1'b0);
        run(32'h05000005, 3, 3'h2, 1'b1);
        wr(osd_pkg::REG_WIN0_MODE, 32'h0e9);
        feed(32'h0000ffff);
        px(24'h102030, 24'hff8080);
        px(24'h102030, 24'h008080);
        wr(osd_pkg::REG_TRANSP, 32'h0000ffff);
        wr(osd_pkg::REG_WIN0_MODE, 32'h019);
        feed(32'h0000ffff);
        px(24'h405060, 24'h405060);
        px(24'h405060, 24'h008080);
        // frozen clock enable drops the write
        clkEn <= 1'b0;
        wr(osd_pkg::REG_TRANSP, 32'h00001234);
        clkEn <= 1'b1;
        rd(osd_pkg::REG_TRANSP, 32'h0000ffff);
        // window 1 as attribute plane over a 4-bit window 0, global blink off
        wr(osd_pkg::REG_WIN0_MODE, 32'h005);
        wr(osd_pkg::REG_WIN1_MODE, 32'h105);
        feed(32'h36214f70, 1'b1);
        feed(32'hffffffff, 1'b0);
        for (int i = 0; i < 8; i++) begin
            attrVal = int'(32'h36214f70 >> (8 * (i / 2) + 4 - 4 * (i % 2))) & 15;
            attrVid = {8'(i * 16), 16'h6090};
            px(attrVid, mx(24'h0f0f0f, attrVid, 3'(attrVal), 1'b0));
        end
        // no window holds a word: video passes unchanged
        px(24'h123456, 24'h123456);
        summarize();
    end
endmodule // osd_bitmap_pixel_path_test
